/* verilog/arfq_pkg.sv */
// shared constants and carrier types of the result queue and window compare
package arfq_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_QUEUE = 8'h04;
  localparam logic [7:0] ADDR_LOWER = 8'h08;
  localparam logic [7:0] ADDR_UPPER = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // queue geometry
  localparam int QUEUE_DEPTH = 16;
  localparam logic [4:0] QUEUE_FULL_COUNT = 5'h10;
  localparam logic [4:0] LEVEL_ONE_COUNT = 5'h0C;
  localparam logic [4:0] LEVEL_TWO_COUNT = 5'h08;

  // configuration register bit positions
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_SCALE_BIT = 1;
  localparam int CFG_INSIDE_IE_BIT = 2;
  localparam int CFG_OUTSIDE_IE_BIT = 3;
  localparam logic [3:0] CFG_RESET = 4'h0;

  // status register bit positions
  localparam int ST_LEVEL_ONE_BIT = 0;
  localparam int ST_LEVEL_TWO_BIT = 1;
  localparam int ST_INSIDE_BIT = 2;
  localparam int ST_OUTSIDE_BIT = 3;
  localparam int ST_CONV_BIT = 4;
  localparam logic [4:0] STATUS_RESET = 5'h00;

  // queue register field positions
  localparam int QUEUE_COUNT_LSB = 20;
  localparam int QUEUE_SLOT_LSB = 28;

  // limit reset value
  localparam logic [19:0] LIMIT_RESET = 20'h00000;

  // sample count codes, code k means 2**k samples
  localparam logic [2:0] SAMPLES_128 = 3'h7;
  localparam logic [2:0] FRACTION_BITS = 3'h6;

  // integer bits kept for each precision
  localparam logic [19:0] MASK_14 = 20'hFFFFF;
  localparam logic [19:0] MASK_12 = 20'h3FFFF;
  localparam logic [19:0] MASK_10 = 20'h0FFFF;
  localparam logic [19:0] MASK_8 = 20'h03FFF;

  // bus transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // precision modes of a slot
  typedef enum logic [1:0] {
    PREC_14 = 2'b00,
    PREC_12 = 2'b01,
    PREC_10 = 2'b10,
    PREC_8 = 2'b11
  } arfq_prec_e;

  // finished accumulation handed over by the slot logic
  typedef struct packed {
    logic valid;
    logic [2:0] slot;
    logic [2:0] samples;
    arfq_prec_e prec;
    logic win_en;
    logic [20:0] accum;
  } arfq_result_s;

  // one stored queue entry
  typedef struct packed {
    logic [2:0] slot;
    logic [19:0] data;
  } arfq_entry_s;

endpackage

/* verilog/arfq_mem.sv */
// sixteen entry storage of the result queue with registered read data
`timescale 1ns/10ps
module arfq_mem (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire arfq_pkg::arfq_entry_s wr_data,
  input wire logic [3:0] rd_addr,
  output arfq_pkg::arfq_entry_s rd_data
);
  import arfq_pkg::*;

  // entry storage, no reset needed since count guards validity
  arfq_entry_s mem_q [QUEUE_DEPTH];

  // write port
  always_ff @(posedge hclk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // read port, write data bypasses when both hit the same slot
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_data <= '0;
    end else if (wr_en && (wr_addr == rd_addr)) begin
      rd_data <= wr_data;
    end else begin
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule // arfq_mem

/* verilog/arfq_top.sv */
// result queue, fill flags and window comparator with an ahb-lite slave
`timescale 1ns/10ps
module arfq_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire arfq_pkg::arfq_result_s result,
  output logic conv_done,
  output logic queue_full,
  output logic inside_irq,
  output logic outside_irq
);
  import arfq_pkg::*;

  // bring a finished accumulation into queue format
  function automatic logic [19:0] fmt_result(
    input logic [20:0] acc,
    input logic [2:0] smp,
    input arfq_prec_e prec
  );
    logic [26:0] wide;
    logic [19:0] keep;
    wide = '0;
    keep = MASK_14;
    if (smp == SAMPLES_128) begin
      // one fraction bit too many, drop the lowest
      wide = {7'h00, acc[20:1]};
    end else begin
      // fewer samples, shift up to six fraction bits
      wide = {6'h00, acc} << (FRACTION_BITS - smp);
    end
    case (prec)
      PREC_14: keep = MASK_14;
      PREC_12: keep = MASK_12;
      PREC_10: keep = MASK_10;
      PREC_8: keep = MASK_8;
      default: keep = MASK_14;
    endcase
    return wide[19:0] & keep;
  endfunction

  // shift a 14.6 limit down to the slot's precision when asked
  function automatic logic [19:0] scale_limit(
    input logic [19:0] lim,
    input logic scale,
    input arfq_prec_e prec
  );
    logic [2:0] sh;
    sh = {prec, 1'b0};
    if (scale) begin
      return lim >> sh;
    end
    return lim;
  endfunction

  // bus address phase capture
  logic wr_pend_q; // write data phase pending
  logic [7:0] wr_addr_q; // address of that write
  logic acc_ok; // valid word access in address phase
  logic rd_take; // read taken this cycle
  logic wr_data; // write data phase happening now

  // software visible state
  logic [3:0] cfg_q; // enable, scale, inside ie, outside ie
  logic [19:0] lower_q; // window lower limit
  logic [19:0] upper_q; // window upper limit
  logic [4:0] status_q; // sticky status bits

  // queue pointers and live count
  logic [3:0] wr_ptr_q;
  logic [3:0] rd_ptr_q;
  logic [3:0] rd_ptr_d;
  logic [4:0] count_q;
  arfq_entry_s head; // oldest entry out of memory
  logic q_has_data; // queue holds at least one entry

  // queue events
  logic enable; // global functional enable
  logic push; // result accepted into the queue
  logic pop_req; // write to queue register
  logic pop; // pop that really removes an entry
  logic [19:0] fmt_data; // formatted incoming result
  logic [19:0] lim_lo; // possibly scaled lower limit
  logic [19:0] lim_hi; // possibly scaled upper limit
  logic in_window; // incoming result inside window
  logic [4:0] st_set; // status bits set by hardware
  logic [4:0] st_clr; // status bits cleared by software

  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // valid access from the address phase
  assign acc_ok = hsel && hready && (htrans == HTRANS_NONSEQ) &&
    (hsize == HSIZE_WORD);
  assign rd_take = acc_ok && !hwrite;
  assign wr_data = wr_pend_q;
  // storage has no reset, so an empty queue must not show its words
  assign q_has_data = (count_q != 5'h00);

  // remember write address until its data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      // writes above the mapped page are ignored, not aliased
      wr_pend_q <= acc_ok && hwrite && (haddr[31:8] == 24'h000000);
      wr_addr_q <= haddr[7:0];
    end
  end

  // read data registered at the address phase, stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_take) begin
      if (haddr[31:8] != 24'h000000) begin
        // unmapped reads as zero
        hrdata <= 32'h00000000;
      end else begin
        case (haddr[7:0])
          ADDR_CFG: hrdata <= {28'h0000000, cfg_q};
          ADDR_QUEUE: begin
            // oldest entry plus live count
            hrdata <= 32'h00000000;
            hrdata[19:0] <= q_has_data ? head.data : 20'h00000;
            hrdata[QUEUE_COUNT_LSB +: 5] <= count_q;
            hrdata[QUEUE_SLOT_LSB +: 3] <= q_has_data ? head.slot : 3'h0;
          end
          ADDR_LOWER: hrdata <= {12'h000, lower_q};
          ADDR_UPPER: hrdata <= {12'h000, upper_q};
          ADDR_STATUS: hrdata <= {27'h0000000, status_q};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // configuration register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= CFG_RESET;
    end else if (wr_data && (wr_addr_q == ADDR_CFG)) begin
      cfg_q <= hwdata[3:0];
    end
  end

  // window limit registers, shared by all slots
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lower_q <= LIMIT_RESET;
      upper_q <= LIMIT_RESET;
    end else if (wr_data) begin
      if (wr_addr_q == ADDR_LOWER) begin
        lower_q <= hwdata[19:0];
      end
      if (wr_addr_q == ADDR_UPPER) begin
        upper_q <= hwdata[19:0];
      end
    end
  end

  assign enable = cfg_q[CFG_ENABLE_BIT];

  // full queue refuses results, nothing is overwritten
  assign queue_full = (count_q == QUEUE_FULL_COUNT);
  assign push = result.valid && enable && !queue_full;
  assign conv_done = push;

  // any write value pops, but only a non-empty queue
  assign pop_req = wr_data && (wr_addr_q == ADDR_QUEUE);
  assign pop = pop_req && (count_q != 5'h00) && enable;

  // read pointer next value feeds the memory so head tracks it
  always_comb begin
    rd_ptr_d = rd_ptr_q;
    if (!enable) begin
      rd_ptr_d = 4'h0;
    end else if (pop) begin
      rd_ptr_d = rd_ptr_q + 4'h1;
    end
  end

  // queue pointers and live count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      count_q <= 5'h00;
    end else if (!enable) begin
      // disabled acts as a soft reset of the queue
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      count_q <= 5'h00;
    end else begin
      rd_ptr_q <= rd_ptr_d;
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 4'h1;
      end
      if (push && !pop) begin
        count_q <= count_q + 5'h01;
      end else if (pop && !push) begin
        count_q <= count_q - 5'h01;
      end
    end
  end

  // format and window compare of the incoming result
  assign fmt_data = fmt_result(result.accum, result.samples, result.prec);
  assign lim_lo = scale_limit(lower_q, cfg_q[CFG_SCALE_BIT], result.prec);
  assign lim_hi = scale_limit(upper_q, cfg_q[CFG_SCALE_BIT], result.prec);
  assign in_window = (fmt_data >= lim_lo) && (fmt_data <= lim_hi);

  // entry storage
  arfq_mem u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(push),
    .wr_addr(wr_ptr_q),
    .wr_data({result.slot, fmt_data}),
    .rd_addr(rd_ptr_d),
    .rd_data(head)
  );

  // hardware sets of the status bits
  always_comb begin
    st_set = 5'h00;
    st_set[ST_CONV_BIT] = push;
    // level flags only when a push alone reaches the mark
    st_set[ST_LEVEL_ONE_BIT] = push && !pop &&
      (count_q == LEVEL_ONE_COUNT - 5'h01);
    st_set[ST_LEVEL_TWO_BIT] = push && !pop &&
      (count_q == LEVEL_TWO_COUNT - 5'h01);
    // every qualifying sample sets again
    st_set[ST_INSIDE_BIT] = push && result.win_en && in_window;
    st_set[ST_OUTSIDE_BIT] = push && result.win_en && !in_window;
  end

  // software clears with write one to clear
  assign st_clr = (wr_data && (wr_addr_q == ADDR_STATUS)) ?
    hwdata[4:0] : 5'h00;

  // sticky status, a set in the clear cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= (status_q & ~st_clr) | st_set;
    end
  end

  // window interrupts gated by their own enables
  assign inside_irq = status_q[ST_INSIDE_BIT] &&
    cfg_q[CFG_INSIDE_IE_BIT];
  assign outside_irq = status_q[ST_OUTSIDE_BIT] &&
    cfg_q[CFG_OUTSIDE_IE_BIT];

  // checks of the queue and window behaviour
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // a pop alone
  sequence s_pop_only;
    pop && !push;
  endsequence

  // a push alone
  sequence s_push_only;
    push && !pop;
  endsequence

  a_push_pulse: assert property (
    result.valid && enable && (count_q != QUEUE_FULL_COUNT) |->
      conv_done ##1 (count_q != 5'h00))
    else $error("accepted result did not push");

  a_pop_drops: assert property (s_pop_only |=>
    (count_q == $past(count_q) - 5'h01) &&
      (rd_ptr_q == $past(rd_ptr_q) + 4'h1))
    else $error("pop did not remove one entry");

  a_read_no_effect: assert property (
    rd_take && !push && !pop && enable |=>
      $stable(count_q) && $stable(rd_ptr_q))
    else $error("queue read changed queue state");

  a_live_count: assert property (
    rd_take && (haddr == {24'h000000, ADDR_QUEUE}) |=>
      hrdata[QUEUE_COUNT_LSB +: 5] == $past(count_q))
    else $error("count field not the live count");

  a_full_hold: assert property (
    queue_full && enable && !pop_req |=>
      queue_full && $stable(wr_ptr_q))
    else $error("full queue accepted a result");

  a_empty_pop: assert property (
    pop_req && (count_q == 5'h00) && !push |=>
      (count_q == 5'h00) && $stable(rd_ptr_q))
    else $error("pop on empty queue moved state");

  a_level_one: assert property (
    s_push_only ##0 (count_q == 5'h0B) |=>
      status_q[ST_LEVEL_ONE_BIT] && (count_q == LEVEL_ONE_COUNT))
    else $error("level one flag not set at twelve");

  a_level_two: assert property (
    s_push_only ##0 (count_q == 5'h07) |=>
      status_q[ST_LEVEL_TWO_BIT] && (count_q == LEVEL_TWO_COUNT))
    else $error("level two flag not set at eight");

  a_disable_empty: assert property (
    !enable |=> (count_q == 5'h00) && (wr_ptr_q == 4'h0))
    else $error("disable did not empty the queue");

  a_window_sets: assert property (
    push && result.win_en |=>
      status_q[ST_INSIDE_BIT] || status_q[ST_OUTSIDE_BIT])
    else $error("window sample set no status");

  a_no_compare_off: assert property (
    push && !result.win_en && !status_q[ST_INSIDE_BIT] &&
      !status_q[ST_OUTSIDE_BIT] |=>
      !status_q[ST_INSIDE_BIT] && !status_q[ST_OUTSIDE_BIT])
    else $error("slot without compare set window status");

endmodule // arfq_top

/* bench/arfq_slot_model.sv */
// behavioural model of the slot accumulator that feeds finished results
`timescale 1ns/10ps
module arfq_slot_model (
  input wire logic hclk,
  output arfq_pkg::arfq_result_s result
);
  import arfq_pkg::*;

  // idle at time zero, no result pending
  initial begin
    result = '0;
  end

  // one valid pulse per finished accumulation, one clock wide
  task automatic send(input logic [2:0] s, input logic [2:0] k,
                      input arfq_prec_e p, input logic w,
                      input logic [20:0] a);
    result <= {1'b1, s, k, p, w, a};
    @(posedge hclk);
    // stale fields are inverted so they never look like a held result
    result <= {1'b0, ~s, ~k, arfq_prec_e'(~p), ~w, ~a};
  endtask
endmodule // arfq_slot_model

/* bench/testbench.sv */
// self-checking bench of the result queue and window compare
`timescale 1ns/10ps
module testbench;
  import arfq_pkg::*;

  logic hclk = 1'b0; // system clock
  logic hresetn = 1'b0; // active low reset
  logic hsel = 1'b0; // bus select
  logic [31:0] haddr = 32'h0; // bus address
  logic [1:0] htrans = 2'h0; // transfer type
  logic hwrite = 1'b0; // write strobe
  logic [2:0] hsize = 3'h0; // transfer size
  logic [31:0] hwdata = 32'h0; // write data
  logic hready, hreadyout, hresp, conv_done, queue_full;
  logic inside_irq, outside_irq;
  logic [31:0] hrdata, rd, exp, w; // bus read data and scratch
  logic [20:0] acc; // accumulator value sent
  arfq_result_s result; // result from the slot model
  int n_mismatch = 0; // mismatch counter
  int n_checks = 0; // comparison counter
  int cyc = 0; // cycle counter for the hang guard
  // registers read back after reset, plus an unmapped word
  logic [7:0] alist [6] = '{ADDR_CFG, ADDR_QUEUE, ADDR_LOWER, ADDR_UPPER,
                            ADDR_STATUS, 8'h20};
  // window cases: cfg, {out,in}, prec, win enable, sample
  logic [31:0] wtab [11] = '{32'hD4101000, 32'hD4102000, 32'hD8100FFF,
                            32'hD8102001, 32'hD0002001, 32'h14101800,
                            32'hF7100060, 32'hFB100090, 32'hDB100060,
                            32'hF5100600, 32'hF6100180};

  assign hready = hreadyout; // single slave drives the bus ready

  // 20 MHz clock
  always #25 hclk = ~hclk;

  arfq_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .result(result),
    .conv_done(conv_done), .queue_full(queue_full),
    .inside_irq(inside_irq), .outside_irq(outside_irq));

  arfq_slot_model i_model (.hclk(hclk), .result(result));

  // compare and count
  task check(input string name, input logic [31:0] seen,
             input logic [31:0] ex);
    n_checks++;
    if (seen !== ex) begin
      $display("MISMATCH %s expected %h seen %h", name, ex, seen);
      n_mismatch++;
    end
  endtask

  // verdict and end of run
  task test_done();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // one single word transfer; read data lands in rd
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    check("bus_resp", {30'h0, hreadyout, hresp}, 32'h2);
  endtask

  // push one result and look at the completion pulse in its cycle
  task push(input logic [2:0] s, input logic [2:0] k, input arfq_prec_e p,
            input logic wn, input logic [20:0] a, input logic e);
    i_model.send(s, k, p, wn, a);
    check("conv_done", {31'h0, conv_done}, {31'h0, e});
    @(posedge hclk);
  endtask

  // expected queue data for a sample count code and precision
  function automatic logic [19:0] fmt(logic [20:0] a, logic [2:0] k,
                                      arfq_prec_e p);
    logic [20:0] s;
    s = (k == 3'h7) ? (a >> 1) : (a << (3'h6 - k));
    case (p)
      PREC_14: return s[19:0] & MASK_14;
      PREC_12: return s[19:0] & MASK_12;
      PREC_10: return s[19:0] & MASK_10;
      default: return s[19:0] & MASK_8;
    endcase
  endfunction

  // hang guard
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      test_done();
    end
  end

  // main sequence
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values and an unmapped address
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, alist[i], 32'h0);
      check("reset_read", rd, 32'h0);
    end
    bus(1'b1, ADDR_CFG, 32'h1);
    // every precision with every sample count
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 8; k++) begin
        acc = 21'h1F5A5B & ((21'h1 << (14 + k)) - 21'h1);
        push(k[2:0], k[2:0], arfq_prec_e'(p[1:0]), 1'b0, acc, 1'b1);
        exp = {1'b0, k[2:0], 3'h0, 5'h01,
               fmt(acc, k[2:0], arfq_prec_e'(p[1:0]))};
        bus(1'b0, ADDR_QUEUE, 32'h0);
        check("queue_word", rd, exp);
        bus(1'b0, ADDR_QUEUE, 32'h0);
        check("queue_reread", rd, exp);
        bus(1'b1, ADDR_QUEUE, 32'hA5A5A5A5);
        bus(1'b0, ADDR_QUEUE, 32'h0);
        check("pop_count", {27'h0, rd[24:20]}, 32'h0);
      end
    end
    // fill past full, watching both level flags
    bus(1'b1, ADDR_STATUS, 32'h1F);
    for (int i = 0; i < 17; i++) begin
      push(i[2:0], 3'h6, PREC_14, 1'b0, 21'(i + 1), i < 16);
      bus(1'b0, ADDR_STATUS, 32'h0);
      check("level_flags", {30'h0, rd[1:0]},
            {30'h0, i >= 7, i >= 11});
      check("queue_full", {31'h0, queue_full},
            {31'h0, i >= 15});
    end
    bus(1'b1, ADDR_QUEUE, 32'h0);
    push(3'h5, 3'h6, PREC_14, 1'b0, 21'h55, 1'b1);
    // drain in arrival order with a live count
    for (int j = 0; j < 16; j++) begin
      bus(1'b0, ADDR_QUEUE, 32'h0);
      exp = (j < 15) ? {1'b0, 3'(j + 1), 3'h0, 5'(16 - j), 20'(j + 2)}
                     : {1'b0, 3'h5, 3'h0, 5'h01, 20'h55};
      check("drain", rd, exp);
      bus(1'b1, ADDR_QUEUE, 32'h0);
    end
    // pop while empty must not disturb the next result
    bus(1'b1, ADDR_QUEUE, 32'h0);
    push(3'h2, 3'h6, PREC_14, 1'b0, 21'h123, 1'b1);
    bus(1'b0, ADDR_QUEUE, 32'h0);
    check("pop_empty", rd, {1'b0, 3'h2, 3'h0, 5'h01, 20'h123});
    // disabling empties the queue and drops results
    push(3'h3, 3'h6, PREC_14, 1'b0, 21'h77, 1'b1);
    bus(1'b1, ADDR_CFG, 32'h0);
    // the queue empties at the edge after the enable bit drops
    @(posedge hclk);
    bus(1'b0, ADDR_QUEUE, 32'h0);
    check("disable_count", {27'h0, rd[24:20]}, 32'h0);
    push(3'h3, 3'h6, PREC_14, 1'b0, 21'h77, 1'b0);
    bus(1'b1, ADDR_CFG, 32'h1);
    push(3'h4, 3'h6, PREC_14, 1'b0, 21'h88, 1'b1);
    bus(1'b0, ADDR_QUEUE, 32'h0);
    check("reenable", rd, {1'b0, 3'h4, 3'h0, 5'h01, 20'h88});
    bus(1'b1, ADDR_QUEUE, 32'h0);
    // window compare cases, raw and scaled limits
    bus(1'b1, ADDR_LOWER, 32'h1000);
    bus(1'b1, ADDR_UPPER, 32'h2000);
    bus(1'b0, ADDR_LOWER, 32'h0);
    check("lower_rw", rd, 32'h1000);
    for (int t = 0; t < 11; t++) begin
      w = wtab[t];
      bus(1'b1, ADDR_CFG, {28'h0, w[31:28]});
      bus(1'b1, ADDR_STATUS, 32'h1F);
      push(3'h1, 3'h6, arfq_prec_e'(w[25:24]), w[20], {1'b0, w[19:0]},
           1'b1);
      bus(1'b0, ADDR_STATUS, 32'h0);
      check("window_status", {29'h0, rd[4:2]},
            {29'h0, 1'b1, w[27:26]});
      check("window_irq", {30'h0, outside_irq, inside_irq},
            {30'h0, w[27] & w[31], w[26] & w[30]});
      bus(1'b1, ADDR_QUEUE, 32'h0);
    end
    test_done();
  end
endmodule // testbench
